// >>> src/gpo_pkg.sv
package gpo_pkg;

	// ------------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------------
	localparam int NUM_PORTS = 4;
	localparam int PORT_W    = 8;
	localparam int PIN_W     = NUM_PORTS * PORT_W;
	localparam int ADDR_W    = 12;

	// ------------------------------------------------------------------
	// Register indices; the byte address is four times the index
	// ------------------------------------------------------------------
	localparam logic [3:0] IDX_INPUT_LEVEL_A  = 4'h0;
	localparam logic [3:0] IDX_DIRECTION_A    = 4'h1;
	localparam logic [3:0] IDX_OUTPUT_LATCH_A = 4'h2;
	localparam logic [3:0] IDX_INPUT_LEVEL_B  = 4'h3;
	localparam logic [3:0] IDX_DIRECTION_B    = 4'h4;
	localparam logic [3:0] IDX_OUTPUT_LATCH_B = 4'h5;
	localparam logic [3:0] IDX_INPUT_LEVEL_C  = 4'h6;
	localparam logic [3:0] IDX_DIRECTION_C    = 4'h7;
	localparam logic [3:0] IDX_OUTPUT_LATCH_C = 4'h8;
	localparam logic [3:0] IDX_INPUT_LEVEL_D  = 4'h9;
	localparam logic [3:0] IDX_DIRECTION_D    = 4'hA;
	localparam logic [3:0] IDX_OUTPUT_LATCH_D = 4'hB;
	localparam logic [9:0] IDX_SYSTEM_CONTROL = 10'h035;
	localparam logic [9:0] NUM_PORT_REGS      = 10'h00C;
	localparam logic [9:0] DATA_SPACE_OFFSET  = 10'h020;

	// Decoder codes beyond the port register indices.
	localparam logic [3:0] SEL_SYSTEM_CONTROL = 4'hC;
	localparam logic [3:0] SEL_NONE           = 4'hF;

	localparam logic [3:0] IDX_INPUT  [NUM_PORTS] = '{IDX_INPUT_LEVEL_A, IDX_INPUT_LEVEL_B,
		IDX_INPUT_LEVEL_C, IDX_INPUT_LEVEL_D};
	localparam logic [3:0] IDX_DIR    [NUM_PORTS] = '{IDX_DIRECTION_A, IDX_DIRECTION_B,
		IDX_DIRECTION_C, IDX_DIRECTION_D};
	localparam logic [3:0] IDX_LATCH  [NUM_PORTS] = '{IDX_OUTPUT_LATCH_A, IDX_OUTPUT_LATCH_B,
		IDX_OUTPUT_LATCH_C, IDX_OUTPUT_LATCH_D};

	// ------------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------------
	localparam int         GLOBAL_PULLUP_OFF_BIT = 4;
	localparam logic [7:0] SYSTEM_CONTROL_WMASK  = 8'hF3;
	localparam logic [7:0] SYSTEM_CONTROL_RESET  = 8'h00;
	localparam logic [7:0] DIRECTION_RESET       = 8'h00;
	localparam logic [7:0] OUTPUT_LATCH_RESET    = 8'h00;
	localparam logic [7:0] SYNC_RESET            = 8'h00;

	// Bit positions of the lower port D pins in the flat pin vector.
	localparam int PORT_D_BASE = 24;
	localparam int PD0 = PORT_D_BASE + 0;
	localparam int PD1 = PORT_D_BASE + 1;
	localparam int PD2 = PORT_D_BASE + 2;
	localparam int PD3 = PORT_D_BASE + 3;

endpackage

// >>> src/gpo_top.sv
// How it works
// R1: Serial1 receiver forces PD2 input, feeds it.
// R2: Forced PD2 pull-up follows latch, gated globally.
// R3: Serial0 receiver forces PD0 input, latch pull-up.
// R4: Serial0 transmitter drives PD1, no pull-up.
// R5: PD2 feeds external interrupt zero.
// R6: PD2 feeds pin-change 26, input kept enabled.
// R7: PD1 feeds pin-change 25, input kept enabled.
// R8: PD0 feeds pin-change 24, input kept enabled.
// R9: PD0 is timer3 count input.
// R10: Global pull-up off kills every pull-up.
// R11: Pull-up off bit 4, reset zero, bits 3:2 zero.
// R12: Per-port output latch, reset zero, A at 0x02.
// R13: Per-port direction, reset zero, A at 0x01.
// R14: Per-port input level, A at 0x00.
// R15: Port B registers at 0x03..0x05.
// R16: Port C registers at 0x06..0x08.
// R17: Registers mirrored at I/O offset plus 0x20.
// R18: Serial1 transmitter drives PD3 output.
// R19: Port D registers at 0x09..0x0B.
// R20: Active override replaces register-derived pin control.
// R21: Default: drive latch if output, pull-up if latched input.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module gpo_top
	import gpo_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              SYS_RST,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [ADDR_W-1:0] PADDR,
	input  wire logic [31:0]       PWDATA,
	input  wire logic [3:0]        PSTRB,
	output logic                   PREADY,
	output logic      [31:0]       PRDATA,
	output logic                   PSLVERR,
	input  wire logic [PIN_W-1:0]  PIN_IN,
	output logic      [PIN_W-1:0]  PIN_OUT,
	output logic      [PIN_W-1:0]  PIN_OE,
	output logic      [PIN_W-1:0]  PIN_PULLUP,
	input  wire logic [PIN_W-1:0]  PULLUP_OVERRIDE_ENABLE,
	input  wire logic [PIN_W-1:0]  PULLUP_OVERRIDE_VALUE,
	input  wire logic [PIN_W-1:0]  DIRECTION_OVERRIDE_ENABLE,
	input  wire logic [PIN_W-1:0]  DIRECTION_OVERRIDE_VALUE,
	input  wire logic [PIN_W-1:0]  PIN_VALUE_OVERRIDE_ENABLE,
	input  wire logic [PIN_W-1:0]  PIN_VALUE_OVERRIDE_VALUE,
	input  wire logic [PIN_W-1:0]  INPUT_ENABLE_OVERRIDE_ENABLE,
	input  wire logic [PIN_W-1:0]  INPUT_ENABLE_OVERRIDE_VALUE,
	input  wire logic              SERIAL0_RECEIVER_ENABLE,
	input  wire logic              SERIAL0_TRANSMITTER_ENABLE,
	input  wire logic              SERIAL0_TRANSMIT_OUTPUT,
	input  wire logic              SERIAL1_RECEIVER_ENABLE,
	input  wire logic              SERIAL1_TRANSMITTER_ENABLE,
	input  wire logic              SERIAL1_TRANSMIT_OUTPUT,
	input  wire logic              EXTERNAL_IRQ_ZERO_ENABLE,
	input  wire logic [7:0]        PIN_CHANGE_MASK_D,
	input  wire logic              PIN_CHANGE_GROUP_D_ENABLE,
	output logic                   SERIAL0_RECEIVE_INPUT,
	output logic                   SERIAL1_RECEIVE_INPUT,
	output logic                   EXTERNAL_IRQ_ZERO,
	output logic                   PIN_CHANGE_LINE_24,
	output logic                   PIN_CHANGE_LINE_25,
	output logic                   PIN_CHANGE_LINE_26,
	output logic                   TIMER3_COUNT_INPUT,
	output logic      [PIN_W-1:0]  PIN_DATA_IN,
	output logic                   GLOBAL_PULLUP_OFF
);

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	// Each register takes one aligned word, so the word index is the byte
	// address shifted down by two. Every port register answers at its own
	// index and again at the index plus the data space offset, and so does
	// the system control register. Any other index, and any address that is
	// not word aligned, decodes to no register at all; the bus then reports
	// an error and nothing is written.
	function automatic logic [3:0] gpo_decode(input logic [ADDR_W-1:0] a);
		logic [9:0] w;
		w          = a[ADDR_W-1:2];
		gpo_decode = SEL_NONE;
		if (a[1:0] != 2'b00) begin
			gpo_decode = SEL_NONE;
		end else if (w < NUM_PORT_REGS) begin
			gpo_decode = w[3:0]; // [R12] [R13] [R14] [R15] [R16] [R19]
		end else if (w >= DATA_SPACE_OFFSET && w < DATA_SPACE_OFFSET + NUM_PORT_REGS) begin
			gpo_decode = 4'(w - DATA_SPACE_OFFSET); // [R17]
		end else if (w == IDX_SYSTEM_CONTROL || w == IDX_SYSTEM_CONTROL + DATA_SPACE_OFFSET) begin
			gpo_decode = SEL_SYSTEM_CONTROL; // [R11] [R17]
		end
	endfunction

	logic [3:0]       sel;
	logic             wr_en;
	logic             setup;
	logic [7:0]       rdata;
	logic [31:0]      prdata_q;
	logic [7:0]       system_control_q;
	logic [PIN_W-1:0] direction_q;
	logic [PIN_W-1:0] output_latch_q;
	logic [PIN_W-1:0] pin_meta_q;
	logic [PIN_W-1:0] pin_sync_q;
	logic             global_pullup_off;
	logic [PIN_W-1:0] in_pullup_override_enable;
	logic [PIN_W-1:0] in_pullup_override_value;
	logic [PIN_W-1:0] in_direction_override_enable;
	logic [PIN_W-1:0] in_direction_override_value;
	logic [PIN_W-1:0] in_pin_value_override_enable;
	logic [PIN_W-1:0] in_pin_value_override_value;
	logic [PIN_W-1:0] in_input_enable_override_enable;
	logic [PIN_W-1:0] in_input_enable_override_value;
	logic [PIN_W-1:0] input_enable;
	logic [PIN_W-1:0] din;

	// ------------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------------
	// Every access completes in its first access cycle, so ready is a
	// constant. The error response is raised only in the access phase.
	assign sel     = gpo_decode(PADDR);
	assign setup   = PSEL & ~PENABLE;
	assign wr_en   = PSEL & PENABLE & PWRITE & PSTRB[0] & (sel != SEL_NONE);
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL & PENABLE & (sel == SEL_NONE);
	assign PRDATA  = prdata_q;
	assign global_pullup_off     = system_control_q[GLOBAL_PULLUP_OFF_BIT];

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------
	// Only the lowest byte lane carries register data. A write whose lowest
	// strobe is low is dropped without an error. Bits 3 and 2 of the system
	// control register have no storage; the mask keeps them at zero.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			system_control_q <= SYSTEM_CONTROL_RESET; // [R11]
		end else if (wr_en && sel == SEL_SYSTEM_CONTROL) begin
			system_control_q <= PWDATA[7:0] & SYSTEM_CONTROL_WMASK; // [R11]
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			direction_q <= {NUM_PORTS{DIRECTION_RESET}}; // [R13]
		end else if (wr_en) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (sel == IDX_DIR[p]) begin
					direction_q[p*PORT_W +: PORT_W] <= PWDATA[7:0]; // [R13]
				end
			end
		end
	end

	// Writing ones to an input-level register toggles the matching latch bits.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			output_latch_q <= {NUM_PORTS{OUTPUT_LATCH_RESET}}; // [R12]
		end else if (wr_en) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (sel == IDX_LATCH[p]) begin
					output_latch_q[p*PORT_W +: PORT_W] <= PWDATA[7:0]; // [R12]
				end else if (sel == IDX_INPUT[p]) begin
					output_latch_q[p*PORT_W +: PORT_W] <=
						output_latch_q[p*PORT_W +: PORT_W] ^ PWDATA[7:0]; // [R14]
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Register read mux
	// ------------------------------------------------------------------
	always_comb begin
		rdata = 8'h00;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (sel == IDX_INPUT[p]) begin
				rdata = din[p*PORT_W +: PORT_W]; // [R14]
			end else if (sel == IDX_DIR[p]) begin
				rdata = direction_q[p*PORT_W +: PORT_W];
			end else if (sel == IDX_LATCH[p]) begin
				rdata = output_latch_q[p*PORT_W +: PORT_W];
			end
		end
		if (sel == SEL_SYSTEM_CONTROL) begin
			rdata = system_control_q & SYSTEM_CONTROL_WMASK; // [R11]
		end
	end

	// Read data is captured in the setup cycle and shown for the access phase.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup) begin
			prdata_q <= {24'h00_0000, rdata};
		end
	end

	// ------------------------------------------------------------------
	// Pin input synchroniser
	// ------------------------------------------------------------------
	// Pin levels change with no regard to the clock. Two flip-flops stand
	// between each pin and any logic, so an input-level read lags the pin
	// by two to three clock cycles.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			pin_meta_q <= {NUM_PORTS{SYNC_RESET}};
			pin_sync_q <= {NUM_PORTS{SYNC_RESET}};
		end else begin
			pin_meta_q <= PIN_IN;
			pin_sync_q <= pin_meta_q;
		end
	end

	// ------------------------------------------------------------------
	// Peripheral overrides on the port D pins
	// ------------------------------------------------------------------
	// The serial units claim their pins through these vectors. They rank
	// above the external override inputs, but the serial receivers claim no
	// input enable, so an external input-enable override can still close their pin.
	always_comb begin
		in_pullup_override_enable      = '0;
		in_pullup_override_enable[PD0] = SERIAL0_RECEIVER_ENABLE; // [R3]
		in_pullup_override_enable[PD1] = SERIAL0_TRANSMITTER_ENABLE; // [R4]
		in_pullup_override_enable[PD2] = SERIAL1_RECEIVER_ENABLE; // [R1]
		in_pullup_override_enable[PD3] = SERIAL1_TRANSMITTER_ENABLE; // [R18]
	end

	// A forced input keeps the pull-up that its latch bit asks for.
	always_comb begin
		in_pullup_override_value      = '0;
		in_pullup_override_value[PD0] = output_latch_q[PD0] & ~global_pullup_off; // [R3] [R10]
		in_pullup_override_value[PD1] = 1'b0; // [R4]
		in_pullup_override_value[PD2] = output_latch_q[PD2] & ~global_pullup_off; // [R2] [R10]
		in_pullup_override_value[PD3] = 1'b0; // [R18]
	end

	always_comb begin
		in_direction_override_enable      = '0;
		in_direction_override_enable[PD0] = SERIAL0_RECEIVER_ENABLE; // [R3]
		in_direction_override_enable[PD1] = SERIAL0_TRANSMITTER_ENABLE; // [R4]
		in_direction_override_enable[PD2] = SERIAL1_RECEIVER_ENABLE; // [R1]
		in_direction_override_enable[PD3] = SERIAL1_TRANSMITTER_ENABLE; // [R18]
	end

	always_comb begin
		in_direction_override_value      = '0;
		in_direction_override_value[PD0] = 1'b0; // [R3]
		in_direction_override_value[PD1] = 1'b1; // [R4]
		in_direction_override_value[PD2] = 1'b0; // [R1]
		in_direction_override_value[PD3] = 1'b1; // [R18]
	end

	always_comb begin
		in_pin_value_override_enable      = '0;
		in_pin_value_override_enable[PD1] = SERIAL0_TRANSMITTER_ENABLE; // [R4]
		in_pin_value_override_enable[PD3] = SERIAL1_TRANSMITTER_ENABLE; // [R18]
	end

	always_comb begin
		in_pin_value_override_value      = '0;
		in_pin_value_override_value[PD1] = SERIAL0_TRANSMIT_OUTPUT; // [R4]
		in_pin_value_override_value[PD3] = SERIAL1_TRANSMIT_OUTPUT; // [R18]
	end

	// An enabled interrupt source keeps the input path of its pin open.
	always_comb begin
		in_input_enable_override_enable = '0;
		for (int k = 0; k < PORT_W; k++) begin
			in_input_enable_override_enable[PORT_D_BASE+k] = PIN_CHANGE_MASK_D[k] & PIN_CHANGE_GROUP_D_ENABLE; // [R6] [R7] [R8]
		end
		in_input_enable_override_enable[PD2] = in_input_enable_override_enable[PD2] | EXTERNAL_IRQ_ZERO_ENABLE; // [R5]
	end

	always_comb begin
		in_input_enable_override_value = '0;
		for (int k = 0; k < PORT_W; k++) begin
			in_input_enable_override_value[PORT_D_BASE+k] = 1'b1; // [R6] [R7] [R8]
		end
	end

	// ------------------------------------------------------------------
	// Pull-up control
	// ------------------------------------------------------------------
	// External pull-up requests still give way to the global pull-up off,
	// so software can always kill every pull-up with one bit.
	always_comb begin
		PIN_PULLUP = '0;
		for (int i = 0; i < PIN_W; i++) begin
			PIN_PULLUP[i] = ~direction_q[i] & output_latch_q[i] & ~global_pullup_off; // [R21] [R10]
			if (in_pullup_override_enable[i]) begin
				PIN_PULLUP[i] = in_pullup_override_value[i]; // [R20]
			end else if (PULLUP_OVERRIDE_ENABLE[i]) begin
				PIN_PULLUP[i] = PULLUP_OVERRIDE_VALUE[i] & ~global_pullup_off; // [R20] [R10]
			end
		end
	end

	// ------------------------------------------------------------------
	// Direction control
	// ------------------------------------------------------------------
	// With no override, the direction register alone decides the driver.
	always_comb begin
		PIN_OE = '0;
		for (int i = 0; i < PIN_W; i++) begin
			PIN_OE[i] = direction_q[i]; // [R21]
			if (in_direction_override_enable[i]) begin
				PIN_OE[i] = in_direction_override_value[i]; // [R20]
			end else if (DIRECTION_OVERRIDE_ENABLE[i]) begin
				PIN_OE[i] = DIRECTION_OVERRIDE_VALUE[i]; // [R20]
			end
		end
	end

	// ------------------------------------------------------------------
	// Output value control
	// ------------------------------------------------------------------
	// The value is shown even while the pin is an input; only the driver
	// enable decides whether it reaches the pad.
	always_comb begin
		PIN_OUT = '0;
		for (int i = 0; i < PIN_W; i++) begin
			PIN_OUT[i] = output_latch_q[i]; // [R21]
			if (in_pin_value_override_enable[i]) begin
				PIN_OUT[i] = in_pin_value_override_value[i]; // [R20]
			end else if (PIN_VALUE_OVERRIDE_ENABLE[i]) begin
				PIN_OUT[i] = PIN_VALUE_OVERRIDE_VALUE[i]; // [R20]
			end
		end
	end

	// ------------------------------------------------------------------
	// Input enable control
	// ------------------------------------------------------------------
	// Every input path is open unless an override with value zero closes it.
	always_comb begin
		input_enable = '0;
		for (int i = 0; i < PIN_W; i++) begin
			input_enable[i] = 1'b1;
			if (in_input_enable_override_enable[i]) begin
				input_enable[i] = in_input_enable_override_value[i]; // [R20]
			end else if (INPUT_ENABLE_OVERRIDE_ENABLE[i]) begin
				input_enable[i] = INPUT_ENABLE_OVERRIDE_VALUE[i]; // [R20]
			end
		end
	end

	// ------------------------------------------------------------------
	// Pin input path
	// ------------------------------------------------------------------
	// A closed input path reads as zero rather than as the pin level.
	assign din = pin_sync_q & input_enable;

	// ------------------------------------------------------------------
	// Tap-offs to peripherals
	// ------------------------------------------------------------------
	// Port pin levels for the rest of the chip.
	assign PIN_DATA_IN           = din;

	// Port D pin 0 feeds the first serial receiver, timer 3 and line 24.
	assign SERIAL0_RECEIVE_INPUT = din[PD0]; // [R3]
	assign TIMER3_COUNT_INPUT    = din[PD0]; // [R9]
	assign PIN_CHANGE_LINE_24    = din[PD0]; // [R8]

	// Port D pin 1 feeds pin-change line 25.
	assign PIN_CHANGE_LINE_25    = din[PD1]; // [R7]

	// Port D pin 2 feeds line 26, interrupt zero and the second receiver.
	assign PIN_CHANGE_LINE_26    = din[PD2]; // [R6]
	assign EXTERNAL_IRQ_ZERO     = din[PD2]; // [R5]
	assign SERIAL1_RECEIVE_INPUT = din[PD2]; // [R1]

	// The global pull-up off bit is also offered to other units.
	assign GLOBAL_PULLUP_OFF     = global_pullup_off; // [R10]

endmodule

// >>> dv/gpo_assertions.sv
`timescale 1ns/1ps
module gpo_assertions
	import gpo_pkg::*;
(
	input wire logic             CLK,
	input wire logic             SYS_RST,
	input wire logic [PIN_W-1:0] PIN_IN,
	input wire logic [PIN_W-1:0] PIN_OUT,
	input wire logic [PIN_W-1:0] PIN_OE,
	input wire logic [PIN_W-1:0] PIN_PULLUP,
	input wire logic             SERIAL0_RECEIVER_ENABLE,
	input wire logic             SERIAL0_TRANSMITTER_ENABLE,
	input wire logic             SERIAL0_TRANSMIT_OUTPUT,
	input wire logic             SERIAL1_RECEIVER_ENABLE,
	input wire logic             SERIAL1_TRANSMITTER_ENABLE,
	input wire logic             EXTERNAL_IRQ_ZERO_ENABLE,
	input wire logic             EXTERNAL_IRQ_ZERO,
	input wire logic [7:0]       PIN_CHANGE_MASK_D,
	input wire logic             PIN_CHANGE_GROUP_D_ENABLE,
	input wire logic             PIN_CHANGE_LINE_24,
	input wire logic             PIN_CHANGE_LINE_25,
	input wire logic             GLOBAL_PULLUP_OFF
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	chk_rx0_input: assert property (SERIAL0_RECEIVER_ENABLE |-> !PIN_OE[PD0])
		else $error("rx0 pin driven");
	chk_rx1_input: assert property (SERIAL1_RECEIVER_ENABLE |-> !PIN_OE[PD2]
		&& !(PIN_PULLUP[PD2] && GLOBAL_PULLUP_OFF)) else $error("rx1 pin wrong");
	chk_tx0_drive: assert property (SERIAL0_TRANSMITTER_ENABLE |-> PIN_OE[PD1]
		&& !PIN_PULLUP[PD1] && PIN_OUT[PD1] == SERIAL0_TRANSMIT_OUTPUT) else $error("tx0 pin wrong");
	chk_tx1_drive: assert property (SERIAL1_TRANSMITTER_ENABLE |-> PIN_OE[PD3])
		else $error("tx1 pin not driven");
	chk_pud_all: assert property (GLOBAL_PULLUP_OFF |-> PIN_PULLUP == '0)
		else $error("pull-up on while disabled");
	chk_irq_follow: assert property ((EXTERNAL_IRQ_ZERO_ENABLE && $stable(PIN_IN[PD2])) [*4]
		|-> EXTERNAL_IRQ_ZERO == PIN_IN[PD2]) else $error("irq0 not following pin");
	chk_pc25_follow: assert property ((PIN_CHANGE_MASK_D[1] && PIN_CHANGE_GROUP_D_ENABLE
		&& $stable(PIN_IN[PD1])) [*4] |-> PIN_CHANGE_LINE_25 == PIN_IN[PD1]) else $error("pc25 stale");
	chk_pc24_follow: assert property ((PIN_CHANGE_MASK_D[0] && PIN_CHANGE_GROUP_D_ENABLE
		&& $stable(PIN_IN[PD0])) [*4] |-> PIN_CHANGE_LINE_24 == PIN_IN[PD0]) else $error("pc24 stale");
endmodule
bind gpo_top gpo_assertions chk_i (.CLK, .SYS_RST, .PIN_IN, .PIN_OUT, .PIN_OE, .PIN_PULLUP,
	.SERIAL0_RECEIVER_ENABLE, .SERIAL0_TRANSMITTER_ENABLE, .SERIAL0_TRANSMIT_OUTPUT,
	.SERIAL1_RECEIVER_ENABLE, .SERIAL1_TRANSMITTER_ENABLE, .EXTERNAL_IRQ_ZERO_ENABLE,
	.EXTERNAL_IRQ_ZERO, .PIN_CHANGE_MASK_D, .PIN_CHANGE_GROUP_D_ENABLE, .PIN_CHANGE_LINE_24,
	.PIN_CHANGE_LINE_25, .GLOBAL_PULLUP_OFF);

// >>> dv/gpo_pins_model.sv
`timescale 1ns/1ps
module gpo_pins_model
	import gpo_pkg::*;
(
	input  wire logic             clk,
	input  wire logic [PIN_W-1:0] pin_out,
	input  wire logic [PIN_W-1:0] pin_oe,
	input  wire logic [PIN_W-1:0] pin_pullup,
	input  wire logic [PIN_W-1:0] ext_en,
	input  wire logic [PIN_W-1:0] ext_val,
	output logic      [PIN_W-1:0] pin_in
);
	// A pin that nobody drives or pulls toggles every cycle, so no stale level is read.
	logic [PIN_W-1:0] float_q = '0;
	always_ff @(posedge clk) float_q <= ~float_q;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & (pin_pullup | float_q));
endmodule

// >>> dv/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
	import gpo_pkg::*;
	logic CLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, err;
	logic [ADDR_W-1:0] PADDR = '0;
	logic [3:0] PSTRB = 4'hF;
	logic [31:0] PWDATA = '0, PRDATA, rd, seed = 32'h0000_0040;
	logic [7:0] v, w, PIN_CHANGE_MASK_D = '0;
	logic [PIN_W-1:0] PIN_IN, PIN_OUT, PIN_OE, PIN_PULLUP, PIN_DATA_IN, ext_en = '0, ext_val = '0;
	logic [PIN_W-1:0] PULLUP_OVERRIDE_ENABLE = '0, PULLUP_OVERRIDE_VALUE = '0;
	logic [PIN_W-1:0] DIRECTION_OVERRIDE_ENABLE = '0, DIRECTION_OVERRIDE_VALUE = '0;
	logic [PIN_W-1:0] PIN_VALUE_OVERRIDE_ENABLE = '0, PIN_VALUE_OVERRIDE_VALUE = '0;
	logic [PIN_W-1:0] INPUT_ENABLE_OVERRIDE_ENABLE = '0, INPUT_ENABLE_OVERRIDE_VALUE = '0;
	logic SERIAL0_RECEIVER_ENABLE = 0, SERIAL0_TRANSMITTER_ENABLE = 0, SERIAL0_TRANSMIT_OUTPUT = 0;
	logic SERIAL1_RECEIVER_ENABLE = 0, SERIAL1_TRANSMITTER_ENABLE = 0, SERIAL1_TRANSMIT_OUTPUT = 0;
	logic EXTERNAL_IRQ_ZERO_ENABLE = 0, PIN_CHANGE_GROUP_D_ENABLE = 0, EXTERNAL_IRQ_ZERO;
	logic SERIAL0_RECEIVE_INPUT, SERIAL1_RECEIVE_INPUT, TIMER3_COUNT_INPUT, GLOBAL_PULLUP_OFF;
	logic PIN_CHANGE_LINE_24, PIN_CHANGE_LINE_25, PIN_CHANGE_LINE_26;
	wire logic [2:0] taps2 = {SERIAL1_RECEIVE_INPUT, EXTERNAL_IRQ_ZERO, PIN_CHANGE_LINE_26};
	wire logic [2:0] taps0 = {SERIAL0_RECEIVE_INPUT, TIMER3_COUNT_INPUT, PIN_CHANGE_LINE_24};
	int n_errors = 0, checks_done = 0;
	gpo_top uut (.*);
	gpo_pins_model pins (.clk(CLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE), .pin_pullup(PIN_PULLUP),
		.ext_en(ext_en), .ext_val(ext_val), .pin_in(PIN_IN));
	always #12.5 CLK = ~CLK;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [11:0] ad(int idx, logic mir);
		return 12'((idx + (mir ? int'(DATA_SPACE_OFFSET) : 0)) * 4);
	endfunction
	task summarize();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task apb(input logic we, input logic [11:0] a, input logic [7:0] d);
		int i;
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= we;
		PADDR <= a;
		PWDATA <= 32'(d);
		@(posedge CLK);
		PENABLE <= 1'b1;
		i = 0;
		do begin
			@(posedge CLK);
			i++;
		end while (PREADY !== 1'b1 && i < 20);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		if (i >= 20) begin
			n_errors++;
			summarize();
		end
	endtask
	task rc(input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		`CHK(rd, 32'(e))
	endtask
	initial begin
		int p;
		repeat (2) @(posedge CLK);
		SYS_RST <= 1'b0;
		for (int k = 0; k < NUM_PORTS; k++) begin
			rc(ad(IDX_DIR[k], 1'b0), 8'h00);
			rc(ad(IDX_LATCH[k], 1'b1), 8'h00);
		end
		rc(ad(IDX_SYSTEM_CONTROL, 1'b0), 8'h00);
		for (int k = 0; k < 16; k++) begin
			p = k % 4;
			v = 8'(rnd());
			w = 8'(rnd());
			apb(1'b1, ad(IDX_DIR[p], k[2]), v);
			apb(1'b1, ad(IDX_LATCH[p], !k[2]), w);
			@(negedge CLK);
			`CHK(PIN_OE[p * 8 +: 8], v)
			`CHK(PIN_OUT[p * 8 +: 8] & v, w & v)
			`CHK(PIN_PULLUP[p * 8 +: 8], ~v & w)
			rc(ad(IDX_DIR[p], !k[2]), v);
			rc(ad(IDX_LATCH[p], k[2]), w);
		end
		apb(1'b1, ad(IDX_LATCH[0], 1'b0), 8'hFF);
		apb(1'b1, ad(IDX_INPUT[0], 1'b0), 8'h0F);
		rc(ad(IDX_LATCH[0], 1'b1), 8'hF0);
		apb(1'b1, ad(IDX_LATCH[0], 1'b0), 8'hFF);
		apb(1'b1, ad(IDX_SYSTEM_CONTROL, 1'b1), 8'hFF);
		rc(ad(IDX_SYSTEM_CONTROL, 1'b0), 8'hF3);
		for (int k = 0; k < NUM_PORTS; k++) apb(1'b1, ad(IDX_DIR[k], 1'b0), 8'h00);
		@(negedge CLK);
		`CHK({GLOBAL_PULLUP_OFF, PIN_PULLUP}, {1'b1, 32'h0000_0000})
		apb(1'b1, ad(IDX_SYSTEM_CONTROL, 1'b0), 8'h00);
		@(negedge CLK);
		`CHK(PIN_PULLUP[7:0], 8'hFF)
		@(posedge CLK);
		ext_en <= '1;
		ext_val <= rnd();
		repeat (4) @(posedge CLK);
		for (int k = 0; k < NUM_PORTS; k++) rc(ad(IDX_INPUT[k], k[0]), ext_val[k * 8 +: 8]);
		EXTERNAL_IRQ_ZERO_ENABLE <= 1'b1;
		PIN_CHANGE_MASK_D <= 8'h07;
		PIN_CHANGE_GROUP_D_ENABLE <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			@(posedge CLK);
			ext_val <= rnd();
			SERIAL0_RECEIVER_ENABLE <= k[0];
			SERIAL1_RECEIVER_ENABLE <= k[1];
			repeat (4) @(posedge CLK);
			@(negedge CLK);
			`CHK(taps2, {3{ext_val[PD2]}})
			`CHK(PIN_CHANGE_LINE_25, ext_val[PD1])
			`CHK(taps0, {3{ext_val[PD0]}})
		end
		@(posedge CLK);
		ext_val <= '1;
		EXTERNAL_IRQ_ZERO_ENABLE <= 1'b0;
		SERIAL0_RECEIVER_ENABLE <= 1'b0;
		SERIAL1_RECEIVER_ENABLE <= 1'b0;
		INPUT_ENABLE_OVERRIDE_ENABLE <= 32'h0700_0000;
		repeat (4) @(posedge CLK);
		@(negedge CLK);
		`CHK({taps2[0], PIN_CHANGE_LINE_25, taps0[0]}, 3'b111)
		@(posedge CLK);
		PIN_CHANGE_GROUP_D_ENABLE <= 1'b0;
		@(negedge CLK);
		`CHK(PIN_DATA_IN[PD2:PD0], 3'b000)
		@(posedge CLK);
		INPUT_ENABLE_OVERRIDE_ENABLE <= '0;
		apb(1'b1, ad(IDX_DIR[3], 1'b0), 8'hFF);
		apb(1'b1, ad(IDX_LATCH[3], 1'b0), 8'hFF);
		SERIAL0_RECEIVER_ENABLE <= 1'b1;
		SERIAL1_RECEIVER_ENABLE <= 1'b1;
		@(negedge CLK);
		`CHK({PIN_OE[PD2], PIN_OE[PD0], PIN_PULLUP[PD2], PIN_PULLUP[PD0]}, 4'b0011)
		apb(1'b1, ad(IDX_SYSTEM_CONTROL, 1'b1), 8'h10);
		@(negedge CLK);
		`CHK(PIN_PULLUP[PD2], 1'b0)
		apb(1'b1, ad(IDX_SYSTEM_CONTROL, 1'b0), 8'h00);
		apb(1'b1, ad(IDX_DIR[3], 1'b0), 8'h00);
		v = 8'(rnd());
		SERIAL0_TRANSMIT_OUTPUT <= v[0];
		SERIAL1_TRANSMIT_OUTPUT <= v[1];
		SERIAL0_TRANSMITTER_ENABLE <= 1'b1;
		SERIAL1_TRANSMITTER_ENABLE <= 1'b1;
		@(negedge CLK);
		`CHK({PIN_OE[PD3], PIN_OE[PD1], PIN_PULLUP[PD3], PIN_PULLUP[PD1]}, 4'b1100)
		`CHK({PIN_OUT[PD3], PIN_OUT[PD1]}, v[1:0])
		@(posedge CLK);
		PULLUP_OVERRIDE_ENABLE <= 32'h0000_00FF;
		DIRECTION_OVERRIDE_ENABLE <= 32'h0000_00FF;
		PIN_VALUE_OVERRIDE_ENABLE <= 32'h0000_00FF;
		for (int k = 0; k < 4; k++) begin
			@(posedge CLK);
			rd = rnd();
			PULLUP_OVERRIDE_VALUE <= {4{rd[7:0]}};
			DIRECTION_OVERRIDE_VALUE <= {4{rd[15:8]}};
			PIN_VALUE_OVERRIDE_VALUE <= {4{rd[23:16]}};
			@(negedge CLK);
			`CHK({PIN_OE[7:0], PIN_OUT[7:0], PIN_PULLUP[7:0]}, {rd[15:8], rd[23:16], rd[7:0]})
		end
		apb(1'b0, 12'h3FC, 8'h00);
		`CHK({err, rd}, {1'b1, 32'h0000_0000})
		summarize();
	end
endmodule
